// ---- src/count_channel.sv ----
// One counter/timer channel: control, time constant, prescaler, down counter.
// Assumes trigger input already synchronised; write strobes are one-cycle pulses.
`timescale 1ns/1ns
module count_channel
   import ctc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ctl_wr,
   input wire logic tc_wr,
   input wire logic [7:0] wr_data,
   input wire logic trig_lvl,
   output logic [7:0] count,
   output logic zero,
   output logic irq_en
);
   logic [7:0] ctl_r;
   logic [7:0] tc_r;
   logic [7:0] cnt_r;
   logic [7:0] pre_r;
   logic run_r;
   logic armed_r;
   logic trig_d_r;
   logic ext_edge;
   logic pre_tick;
   logic tick;
   logic [7:0] pre_last;

   // ==========================================================
   // Event sources
   assign pre_last = ctl_r[CTL_PRE_BIT] ? PRE_LAST_256 : PRE_LAST_16;
   assign ext_edge = ctl_r[CTL_EDGE_BIT] ? (trig_lvl & ~trig_d_r) : (~trig_lvl & trig_d_r);
   assign pre_tick = run_r & ~ctl_r[CTL_MODE_BIT] & (pre_r == pre_last);
   assign tick = run_r & (ctl_r[CTL_MODE_BIT] ? ext_edge : pre_tick);
   assign zero = tick & (cnt_r == CNT_ONE);
   assign count = cnt_r;
   assign irq_en = ctl_r[CTL_IE_BIT];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trig_d_r <= 1'b0;
      end else begin
         trig_d_r <= trig_lvl;
      end
   end

   // ==========================================================
   // Control and time constant registers
   // per-channel registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl_r <= CTL_RESET;
         tc_r <= TC_RESET;
         armed_r <= 1'b0;
      end else begin
         if (ctl_wr) begin
            ctl_r <= wr_data;
            armed_r <= 1'b1;
         end else if (tc_wr) begin
            armed_r <= 1'b0;
         end
         if (tc_wr) begin
            tc_r <= wr_data;
         end
      end
   end

   // ==========================================================
   // Prescaler
   // divide by 16 or 256
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_r <= 8'h00;
      end else if (tc_wr && armed_r && !run_r) begin
         pre_r <= 8'h00;
      end else if (run_r && !ctl_r[CTL_MODE_BIT]) begin
         pre_r <= pre_tick ? 8'h00 : pre_r + 8'h01;
      end
   end

   // ==========================================================
   // Down counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 8'h00;
         run_r <= 1'b0;
      end else if (ctl_wr && wr_data[CTL_RST_BIT]) begin
         run_r <= 1'b0;
      end else if (tc_wr && armed_r && !run_r) begin
         cnt_r <= wr_data;
         run_r <= 1'b1;
      end else if (zero) begin
         cnt_r <= tc_r;
      end else if (tick) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   reload_at_zero_a : assert property (zero && !ctl_wr && !tc_wr |=>
      cnt_r == $past(tc_r))
      else $error("Counter not reloaded at zero");
   prescale_span_a : assert property (pre_tick && !tc_wr |=> !pre_tick [*8])
      else $error("Prescaler ticks too close");
endmodule : count_channel

// ---- src/counter_timer.sv ----
// Four-channel counter/timer with daisy-chained vectored interrupts.
// Assumes processor strobes, data bus and triggers arrive asynchronously.
//
// Function
// - Two-bit channel select picks channel 0 to 3 for each access.
// - Each channel holds time constant, control, down counter, prescaler, all 8-bit.
// - Timer mode prescaler divides the clock by 16 or 256.
// - Counter mode counts external edges; timer mode counts prescaler ticks.
// - Down counter loads from time constant at start and each zero.
// - New time constant takes effect only after present count ends.
// - A read returns the selected channel's down counter at any time.
// - Channels 0 to 2 pulse their zero-count output high at zero.
// - Interrupt-enabled channel requests an interrupt at each zero.
// - Channel 0 has highest interrupt priority, channel 3 lowest.
// - On acknowledge with chain input high, drive winner's vector.
// - Vector is written upper five bits, channel code bits 2:1, bit 0 zero.
// - Lower priority never interrupts unfinished higher service; higher may nest.
// - Bus is watched for return opcode to end service and update chain.
// - All transfers use an 8-bit tri-state data bus, bit 0 least significant.
// - Chain output high only when chain input high and nothing in service.
// - Reset stops channels, clears enables, idles outputs, floats data bus.
// - Control bit 6 set selects counter mode, clear selects timer mode.
// - Control bit 7 enables interrupt; bit 4 selects active edge.
`timescale 1ns/1ns
module counter_timer
   import ctc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic chip_en_n,
   input wire logic iorq_n,
   input wire logic rd_n,
   input wire logic m1_n,
   input wire logic [1:0] channel_select,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic [3:0] external_clock_trigger,
   output logic [2:0] zero_count_pulse_out,
   output logic int_n_out,
   output logic int_oe,
   input wire logic priority_chain_in,
   output logic priority_chain_out
);
   // ==========================================================
   // Input synchronisers
   bus_s bus_s1_r;
   bus_s bus_s2_r;
   bus_s bus_d_r;
   logic [7:0] data_s1_r;
   logic [7:0] data_s2_r;
   logic [1:0] sel_s1_r;
   logic [1:0] sel_s2_r;
   logic [3:0] trig_s1_r;
   logic [3:0] trig_s2_r;
   logic chain_s1_r;
   logic chain_s2_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_s1_r <= '1;
         bus_s2_r <= '1;
         bus_d_r <= '1;
         data_s1_r <= 8'h00;
         data_s2_r <= 8'h00;
         sel_s1_r <= 2'h0;
         sel_s2_r <= 2'h0;
         trig_s1_r <= 4'h0;
         trig_s2_r <= 4'h0;
      end else begin
         bus_s1_r <= '{chip_en_n, iorq_n, rd_n, m1_n};
         bus_s2_r <= bus_s1_r;
         bus_d_r <= bus_s2_r;
         data_s1_r <= data_in;
         data_s2_r <= data_s1_r;
         sel_s1_r <= channel_select;
         sel_s2_r <= sel_s1_r;
         trig_s1_r <= external_clock_trigger;
         trig_s2_r <= trig_s1_r;
      end
   end

   always_ff @(posedge clk) begin
      chain_s1_r <= priority_chain_in;
      chain_s2_r <= chain_s1_r;
   end

   // ==========================================================
   // Cycle decode
   logic wr_act;
   logic rd_act;
   logic ack_act;
   logic fetch_act;
   logic wr_prev;
   logic rd_prev;
   logic ack_prev;
   logic fetch_prev;
   logic wr_start;
   logic rd_start;
   logic ack_start;
   logic fetch_start;

   assign wr_act = ~bus_s2_r.chip_en_n & ~bus_s2_r.iorq_n & bus_s2_r.rd_n & bus_s2_r.m1_n;
   assign rd_act = ~bus_s2_r.chip_en_n & ~bus_s2_r.iorq_n & ~bus_s2_r.rd_n & bus_s2_r.m1_n;
   assign ack_act = ~bus_s2_r.iorq_n & ~bus_s2_r.m1_n;
   assign fetch_act = bus_s2_r.iorq_n & ~bus_s2_r.m1_n & ~bus_s2_r.rd_n;
   assign wr_prev = ~bus_d_r.chip_en_n & ~bus_d_r.iorq_n & bus_d_r.rd_n & bus_d_r.m1_n;
   assign rd_prev = ~bus_d_r.chip_en_n & ~bus_d_r.iorq_n & ~bus_d_r.rd_n & bus_d_r.m1_n;
   assign ack_prev = ~bus_d_r.iorq_n & ~bus_d_r.m1_n;
   assign fetch_prev = bus_d_r.iorq_n & ~bus_d_r.m1_n & ~bus_d_r.rd_n;
   assign wr_start = wr_act & ~wr_prev;
   assign rd_start = rd_act & ~rd_prev;
   assign ack_start = ack_act & ~ack_prev;
   assign fetch_start = fetch_act & ~fetch_prev;

   // ==========================================================
   // Write steering
   logic [3:0] tc_expect_r;
   logic [7:0] vec_base_r;
   logic [3:0] ctl_wr;
   logic [3:0] tc_wr;
   logic vec_wr;

   always_comb begin
      ctl_wr = 4'h0;
      tc_wr = 4'h0;
      vec_wr = 1'b0;
      if (wr_start) begin
         if (tc_expect_r[sel_s2_r]) begin
            tc_wr[sel_s2_r] = 1'b1;
         end else if (data_s2_r[CTL_CMD_BIT]) begin
            ctl_wr[sel_s2_r] = 1'b1;
         end else begin
            vec_wr = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tc_expect_r <= 4'h0;
      end else begin
         tc_expect_r <= (tc_expect_r | ctl_wr) & ~tc_wr;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vec_base_r <= VEC_RESET;
      end else if (vec_wr) begin
         vec_base_r <= data_s2_r;
      end
   end

   // ==========================================================
   // Channels
   logic [7:0] ch_count [NUM_CH];
   logic [3:0] ch_zero;
   logic [3:0] ch_ie;

   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         count_channel u_ch (
            .clk(clk),
            .resetn(resetn),
            .ctl_wr(ctl_wr[i]),
            .tc_wr(tc_wr[i]),
            .wr_data(data_s2_r),
            .trig_lvl(trig_s2_r[i]),
            .count(ch_count[i]),
            .zero(ch_zero[i]),
            .irq_en(ch_ie[i])
         );
      end
   endgenerate

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         zero_count_pulse_out <= 3'h0;
      end else begin
         zero_count_pulse_out <= ch_zero[NUM_ZC-1:0];
      end
   end

   // ==========================================================
   // Interrupt pending, in-service, priority
   logic [3:0] ip_r;
   logic [3:0] ius_r;
   logic [3:0] elig;
   logic [3:0] win;
   logic [3:0] ius_low;
   logic [1:0] win_code;
   logic prev_ed_r;
   logic ret_seen;

   always_comb begin
      logic blocked;
      blocked = 1'b0;
      elig = 4'h0;
      win = 4'h0;
      ius_low = 4'h0;
      win_code = 2'h0;
      for (int i = 0; i < NUM_CH; i++) begin
         blocked = blocked | ius_r[i];
         elig[i] = ip_r[i] & ~blocked;
      end
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (elig[i]) begin
            win = 4'h0;
            win[i] = 1'b1;
            win_code = i[1:0];
         end
         if (ius_r[i]) begin
            ius_low = 4'h0;
            ius_low[i] = 1'b1;
         end
      end
   end

   assign ret_seen = fetch_start & prev_ed_r & (data_s2_r == RETURN_OPCODE);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_ed_r <= 1'b0;
      end else if (fetch_start) begin
         prev_ed_r <= (data_s2_r == RETURN_PREFIX);
      end
   end

   logic take;
   assign take = ack_start & chain_s2_r & (|elig);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ip_r <= 4'h0;
      end else begin
         ip_r <= (ip_r & ~(take ? win : 4'h0)) | (ch_zero & ch_ie);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ius_r <= 4'h0;
      end else begin
         ius_r <= (ius_r | (take ? win : 4'h0)) & ~((ret_seen && chain_s2_r) ? ius_low : 4'h0);
      end
   end

   // ==========================================================
   // Data bus drive
   logic ack_drive_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
         ack_drive_r <= 1'b0;
      end else begin
         if (take) begin
            data_out <= {vec_base_r[7:3], win_code, 1'b0};
            ack_drive_r <= 1'b1;
         end else if (!ack_act) begin
            ack_drive_r <= 1'b0;
         end
         if (rd_act) begin
            data_out <= ch_count[sel_s2_r];
         end
         data_oe <= rd_act | take | (ack_drive_r & ack_act);
      end
   end

   // ==========================================================
   // Interrupt line and chain output
   // idle after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_n_out <= 1'b0;
         int_oe <= 1'b0;
      end else begin
         int_n_out <= 1'b0;
         int_oe <= |elig;
      end
   end

   always_ff @(posedge clk) begin
      priority_chain_out <= chain_s2_r & ~(|ius_r);
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chain_out_gate_a : assert property (priority_chain_out |->
      $past(chain_s2_r) && $past(ius_r) == 4'h0)
      else $error("Chain output high while blocked");
   vector_layout_a : assert property (take |=> data_oe && data_out[0] == 1'b0 &&
      data_out[7:3] == vec_base_r[7:3] && data_out[2:1] == $past(win_code))
      else $error("Vector layout wrong");
   top_priority_a : assert property (take && elig == 4'hc |=>
      ius_r[2] && data_out[2:1] == 2'h2)
      else $error("Channel 2 not served before 3");
   zero_request_a : assert property (ch_zero[1] && ch_ie[1] |=> ip_r[1])
      else $error("Zero count did not request");
   zc_pulse_a : assert property (ch_zero[0] |=> zero_count_pulse_out[0] ##1
      !zero_count_pulse_out[0] || $past(ch_zero[0]))
      else $error("Zero count pulse missing");
   ret_clear_a : assert property (ret_seen && chain_s2_r && ius_r[1:0] == 2'h2 |=>
      !ius_r[1] ##1 priority_chain_out == ($past(chain_s2_r) && $past(ius_r) == 4'h0))
      else $error("Return did not end service");
   nest_block_a : assert property (ius_r[1] |-> elig[3:1] == 3'h0)
      else $error("Lower channel eligible during service");
   read_value_a : assert property (rd_act && !rd_prev |=> data_oe &&
      data_out == $past(ch_count[sel_s2_r]))
      else $error("Read returned wrong count");
   vec_only_ack_a : assert property (!take && !ack_drive_r && !rd_act |=> !data_oe)
      else $error("Bus driven outside read or acknowledge");
endmodule : counter_timer

// ---- src/ctc_pkg.sv ----
// Shared constants and types for the four-channel counter/timer block.
// Assumes a single 250 MHz clock and an active-low asynchronous reset.
package ctc_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_CH = 4;
   localparam int NUM_ZC = 3;
   localparam int DW = 8;

   // ==========================================================
   // Control word field positions
   localparam int CTL_CMD_BIT = 0;
   localparam int CTL_RST_BIT = 1;
   localparam int CTL_EDGE_BIT = 4;
   localparam int CTL_PRE_BIT = 5;
   localparam int CTL_MODE_BIT = 6;
   localparam int CTL_IE_BIT = 7;

   // ==========================================================
   // Reset values and prescaler terminal counts (divide by 16 or 256)
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] TC_RESET = 8'h00;
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] PRE_LAST_16 = 8'h0f;
   localparam logic [7:0] PRE_LAST_256 = 8'hff;
   localparam logic [7:0] CNT_ONE = 8'h01;

   // ==========================================================
   // Opcode bytes of the return-from-interrupt sequence
   localparam logic [7:0] RETURN_PREFIX = 8'hed;
   localparam logic [7:0] RETURN_OPCODE = 8'h4d;

   // Processor strobes, all active low
   typedef struct packed {
      logic chip_en_n;
      logic iorq_n;
      logic rd_n;
      logic m1_n;
   } bus_s;
endpackage : ctc_pkg

// ---- verif/host_bus_model.sv ----
// Host processor model: I/O writes, reads, interrupt acks and return fetches.
// Assumes the device answers on data_out/data_oe within five clocks of a strobe.
`timescale 1ns/1ns
module host_bus_model
   import ctc_pkg::*;
(
   input wire logic clk,
   output bus_s strb,
   output logic [1:0] channel_select,
   output logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   logic [7:0] host_d = 8'h00;
   logic host_drv = 1'b0;
   logic [7:0] page_r = 8'h3c;
   logic [15:0] table_ptr;
   int extra = 0;

   initial begin
      strb = 4'hf;
      channel_select = 2'h0;
   end

   // ==========================================================
   // Data bus
   // Shared tri-state bus
   always_comb begin
      if (data_oe)
         data_in = data_out;
      else if (host_drv)
         data_in = host_d;
      else
         data_in = ~host_d;
   end

   // ==========================================================
   // Bus cycles
   task automatic xfer(input bus_s s, input logic [1:0] ch, input logic drv,
      input logic [7:0] d, output logic [7:0] q, output logic oe);
      @(posedge clk);
      strb <= s;
      channel_select <= ch;
      host_drv <= drv;
      host_d <= d;
      repeat (5 + extra) @(posedge clk);
      #1;
      q = data_out;
      oe = data_oe;
      @(posedge clk);
      strb <= 4'hf;
      host_drv <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
   endtask : xfer

   task automatic wr(input logic [1:0] ch, input logic [7:0] d);
      logic [7:0] q;
      logic oe;
      xfer(4'b0011, ch, 1'b1, d, q, oe);
   endtask : wr

   task automatic prog(input logic [1:0] ch, input logic [7:0] ctl, input logic [7:0] tc);
      wr(ch, ctl | 8'h01);
      wr(ch, tc);
   endtask : prog

   task automatic rd(input logic [1:0] ch, output logic [7:0] q);
      logic oe;
      xfer(4'b0001, ch, 1'b0, host_d, q, oe);
   endtask : rd

   task automatic ack(output logic [7:0] q, output logic oe);
      xfer(4'b1010, channel_select, 1'b0, host_d, q, oe);
      table_ptr = {page_r, q};
   endtask : ack

   task automatic ret_fetch();
      logic [7:0] q;
      logic oe;
      xfer(4'b1100, channel_select, 1'b1, RETURN_PREFIX, q, oe);
      xfer(4'b1100, channel_select, 1'b1, RETURN_OPCODE, q, oe);
   endtask : ret_fetch
endmodule : host_bus_model

// ---- verif/tb.sv ----
// Self-checking bench for the four-channel counter/timer.
// Assumes host_bus_model drives the processor side; bench drives triggers and chain.
`timescale 1ns/1ns
module tb;
   import ctc_pkg::*;
   logic clk, resetn, chain_in, doe, int_n, int_oe, chain_out, oe;
   logic [3:0] trig;
   logic [2:0] zc;
   logic [1:0] sel;
   logic [7:0] din, dout, q, base;
   bus_s strb;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int pcount[3] = '{0, 0, 0};
   int lastp, tc, n, mtc, mcnt, mz;

   counter_timer DUT (.clk(clk), .resetn(resetn), .chip_en_n(strb.chip_en_n),
      .iorq_n(strb.iorq_n), .rd_n(strb.rd_n), .m1_n(strb.m1_n), .channel_select(sel),
      .data_in(din), .data_out(dout), .data_oe(doe), .external_clock_trigger(trig),
      .zero_count_pulse_out(zc), .int_n_out(int_n), .int_oe(int_oe),
      .priority_chain_in(chain_in), .priority_chain_out(chain_out));
   host_bus_model HOST (.clk(clk), .strb(strb), .channel_select(sel), .data_in(din),
      .data_out(dout), .data_oe(doe));

   // ==========================================================
   // Clock and pulse monitor
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      for (int c = 0; c < 3; c++) begin
         if (zc[c] === 1'b1)
            pcount[c] <= pcount[c] + 1;
      end
   end

   // ==========================================================
   // Compare and helper tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic chkb(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkb

   task automatic chki(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chki

   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   task automatic wait_zc(input int ch);
      int start;
      start = pcount[ch];
      for (int k = 0; k < 2000; k++) begin
         @(posedge clk);
         #1;
         if (pcount[ch] != start)
            return;
      end
      err_count++;
      results();
   endtask : wait_zc

   task automatic edge_on(input int ch);
      @(posedge clk);
      trig[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      trig[ch] <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
   endtask : edge_on

   // ==========================================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      chain_in = 1'b1;
      trig = 4'h0;
      n = $urandom(50264);
      repeat (2) @(posedge clk);
      #1;
      chkb(doe, 1'b0);
      chkb(int_oe, 1'b0);
      chk8({5'h00, zc}, 8'h00);
      @(posedge clk);
      resetn <= 1'b1;
      #1;
      chkb(chain_out, 1'b1);
      repeat (6) @(posedge clk);
      #1;
      chkb(chain_out, 1'b1);
      // Timer mode, both prescaler ratios
      for (int i = 0; i < 2; i++) begin
         tc = i ? 1 + $urandom % 2 : 2 + $urandom % 3;
         HOST.prog(2'd0, i ? 8'h21 : 8'h01, tc[7:0]);
         wait_zc(0);
         lastp = cyc;
         wait_zc(0);
         chki(cyc - lastp, tc * (i ? 256 : 16));
      end
      // Counter mode on falling edges, with constant zero as 256
      for (int i = 0; i < 2; i++) begin
         tc = i ? 0 : 2 + $urandom % 5;
         mtc = (tc == 0) ? 256 : tc;
         mcnt = mtc;
         mz = pcount[1];
         HOST.prog(2'd1, 8'h43, tc[7:0]);
         HOST.rd(2'd1, q);
         chk8(q, mcnt[7:0]);
         for (int k = 0; k < (i ? 2 : mtc + 1); k++) begin
            edge_on(1);
            if (mcnt == 1) begin
               mcnt = mtc;
               mz++;
            end else begin
               mcnt--;
            end
            HOST.rd(2'd1, q);
            chk8(q, mcnt[7:0]);
            chki(pcount[1], mz);
         end
      end
      // New constant while counting waits for zero
      HOST.prog(2'd1, 8'h41, 8'h03);
      HOST.rd(2'd1, q);
      chk8(q, mcnt[7:0]);
      // Interrupt priority, nesting and return
      base = 8'($urandom) & 8'hf8;
      HOST.wr(2'd2, base);
      HOST.prog(2'd3, 8'hd1, 8'h01);
      HOST.prog(2'd2, 8'hd1, 8'h01);
      chkb(int_oe, 1'b0);
      edge_on(3);
      chkb(int_oe, 1'b1);
      chkb(int_n, 1'b0);
      edge_on(2);
      HOST.extra = 2;
      HOST.ack(q, oe);
      chk8(q, base | 8'h04);
      chkb(int_oe, 1'b0);
      chkb(chain_out, 1'b0);
      HOST.prog(2'd1, 8'hd3, 8'h01);
      edge_on(1);
      chkb(int_oe, 1'b1);
      HOST.ack(q, oe);
      chk8(q, base | 8'h02);
      HOST.ret_fetch();
      chkb(int_oe, 1'b0);
      HOST.ret_fetch();
      chkb(int_oe, 1'b1);
      chkb(chain_out, 1'b1);
      @(posedge clk);
      chain_in <= 1'b0;
      HOST.ack(q, oe);
      chkb(oe, 1'b0);
      chkb(chain_out, 1'b0);
      @(posedge clk);
      chain_in <= 1'b1;
      HOST.ack(q, oe);
      chk8(q, base | 8'h06);
      HOST.ret_fetch();
      chkb(chain_out, 1'b1);
      results();
   end
endmodule : tb
